// >>> rtl/uitl_irq.v
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
`include "uitl_consts.vh"
module uitl_irq #(
  parameter FIFO_DEPTH = 16,
  parameter BIT_CLKS = 16
) (
  input wire MCLK,
  input wire RST_N,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [7:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  output reg WB_ERR_O,
  input wire [7:0] RX_DATA,
  input wire RX_VALID,
  input wire [4:0] RX_LEVEL,
  input wire [3:0] RX_ERRORS,
  input wire RX_ERR_EVENT,
  input wire [4:0] TX_LEVEL,
  input wire TX_HOLD_EMPTY,
  output reg RX_POP,
  output reg TX_PUSH,
  output reg [7:0] TX_DATA,
  output reg UART_IRQ
);
  localparam [31:0] TO_CLKS = `UITL_TIMEOUT_CHARS * `UITL_CHAR_BITS * BIT_CLKS;
  localparam [15:0] TO_END = TO_CLKS[15:0];
  localparam [15:0] TO_LAST = TO_END - 16'h0001;
  localparam [31:0] DEPTH32 = FIFO_DEPTH;
  localparam [4:0] DEPTH5 = DEPTH32[4:0];

  reg [7:0] irq_enable_reg_r;
  reg [7:0] fifo_control_reg_r;
  reg [3:0] rx_err_r;
  reg line_pend_r;
  reg txe_pend_r;
  reg txe_src_d_r;
  reg cto_pend_r;
  reg [15:0] idle_cnt_r;
  reg [4:0] rx_level_d_r;
  reg [3:0] irq_id;
  reg [31:0] rd_data;
  wire fifo_on;
  wire ptime_on;
  wire rda_src;
  wire txe_src;
  wire tx_empty_norm;
  wire tx_full;
  wire req;
  wire wr_acc;
  wire rd_acc;
  wire mapped;
  wire in_rx_alias;
  wire in_tx_alias;
  wire hit_data;
  wire hit_en;
  wire hit_ident;
  wire hit_line;
  wire hit_fe;
  wire hit_rt;
  wire hit_tt;
  wire hit_stat;
  wire rd_line;
  wire rd_ident;
  wire rd_data_buf;
  wire wr_data_buf;
  wire wr_en_reg;
  wire wr_fifo_ctl;
  wire wr_fe;
  wire wr_rt;
  wire wr_tt;
  wire rx_moved;
  wire cto_src;
  wire irq_pend;
  wire [4:0] thr_level;
  wire [4:0] rx_trig;
  wire [7:0] line_state_reg;

  function in_range;
    input [7:0] a;
    input [7:0] lo;
    input [7:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  // Transmit threshold: empty, 2 entries, quarter, half
  function [4:0] thr_dec;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: thr_dec = 5'h00;
        2'h1: thr_dec = 5'h02;
        2'h2: thr_dec = DEPTH5 >> 2;
        default: thr_dec = DEPTH5 >> 1;
      endcase
    end
  endfunction

  // Receive trigger: one, quarter, half, two short of full
  function [4:0] trig_dec;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: trig_dec = 5'h01;
        2'h1: trig_dec = DEPTH5 >> 2;
        2'h2: trig_dec = DEPTH5 >> 1;
        default: trig_dec = DEPTH5 - 5'h02;
      endcase
    end
  endfunction

  assign req = WB_CYC_I & WB_STB_I & ~WB_ACK_O & ~WB_ERR_O;
  assign in_rx_alias = in_range(WB_ADR_I, `UITL_RX_ALIAS_LO, `UITL_RX_ALIAS_HI);
  assign in_tx_alias = in_range(WB_ADR_I, `UITL_TX_ALIAS_LO, `UITL_TX_ALIAS_HI);
  assign hit_data = (WB_ADR_I == `UITL_DATA_OFS);
  assign hit_en = (WB_ADR_I == `UITL_EN_OFS);
  assign hit_ident = (WB_ADR_I == `UITL_IDENT_OFS);
  assign hit_line = (WB_ADR_I == `UITL_LINE_OFS);
  assign hit_fe = (WB_ADR_I == `UITL_FIFO_EN_ALIAS);
  assign hit_rt = (WB_ADR_I == `UITL_RX_TRIG_ALIAS);
  assign hit_tt = (WB_ADR_I == `UITL_TX_TRIG_ALIAS);
  assign hit_stat = (WB_ADR_I == `UITL_RX_STAT);
  assign mapped = hit_data | in_rx_alias | in_tx_alias | hit_en | hit_ident | hit_line
    | hit_fe | hit_rt | hit_tt | hit_stat;
  assign wr_acc = req & mapped & WB_WE_I & WB_SEL_I[0];
  assign rd_acc = req & mapped & ~WB_WE_I;
  assign rd_line = rd_acc & hit_line;
  assign rd_ident = rd_acc & hit_ident;
  assign rd_data_buf = rd_acc & (hit_data | in_rx_alias);
  assign wr_data_buf = wr_acc & (hit_data | in_tx_alias);
  assign wr_en_reg = wr_acc & hit_en;
  assign wr_fifo_ctl = wr_acc & hit_ident;
  assign wr_fe = wr_acc & hit_fe;
  assign wr_rt = wr_acc & hit_rt;
  assign wr_tt = wr_acc & hit_tt;

  assign fifo_on = fifo_control_reg_r[`UITL_FIFO_ON];
  assign ptime_on = irq_enable_reg_r[`UITL_EN_PTHR] & fifo_on;
  assign thr_level = thr_dec(fifo_control_reg_r[5:4]);
  assign rx_trig = trig_dec(fifo_control_reg_r[7:6]);
  assign rda_src = fifo_on ? (RX_LEVEL >= rx_trig) : RX_VALID;
  assign tx_full = (TX_LEVEL >= DEPTH5);
  // Outside threshold mode: holding register or FIFO empty
  assign tx_empty_norm = fifo_on ? (TX_LEVEL == 5'h00) : TX_HOLD_EMPTY;
  assign txe_src = ptime_on ? (TX_LEVEL <= thr_level) : tx_empty_norm;
  assign line_state_reg = {1'b0, TX_HOLD_EMPTY & (TX_LEVEL == 5'h00),
    (ptime_on ? tx_full : tx_empty_norm),
    rx_err_r, RX_VALID | (RX_LEVEL != 5'h00)};
  assign rx_moved = (RX_LEVEL == 5'h00) | (RX_LEVEL != rx_level_d_r) | rd_data_buf;
  assign cto_src = fifo_on & (RX_LEVEL != 5'h00) & (idle_cnt_r == TO_LAST);

  always @* begin
    if (line_pend_r & irq_enable_reg_r[`UITL_EN_LINE]) begin
      irq_id = `UITL_ID_LINE;
    end else if (rda_src & irq_enable_reg_r[`UITL_EN_DATA]) begin
      irq_id = `UITL_ID_DATA;
    end else if (cto_pend_r & fifo_on & irq_enable_reg_r[`UITL_EN_DATA]) begin
      irq_id = `UITL_ID_CTO;
    end else if (txe_pend_r & irq_enable_reg_r[`UITL_EN_TXE]) begin
      irq_id = `UITL_ID_TXE;
    end else begin
      irq_id = `UITL_ID_NONE;
    end
  end

  assign irq_pend = (irq_id != `UITL_ID_NONE);

  always @* begin
    rd_data = 32'h00000000;
    if (hit_data | in_rx_alias) begin
      rd_data[7:0] = RX_DATA;
    end else if (hit_en) begin
      rd_data[7:0] = irq_enable_reg_r;
    end else if (hit_ident) begin
      rd_data[7:0] = {fifo_on, fifo_on, 2'b00, irq_id};
    end else if (hit_line) begin
      rd_data[7:0] = line_state_reg;
    end else if (hit_fe) begin
      rd_data[0] = fifo_control_reg_r[0];
    end else if (hit_rt) begin
      rd_data[1:0] = fifo_control_reg_r[7:6];
    end else if (hit_tt) begin
      rd_data[1:0] = fifo_control_reg_r[5:4];
    end else if (hit_stat) begin
      rd_data[15:0] = {TX_LEVEL[3:0], 3'b000, RX_LEVEL, 4'h0};
    end
  end

  // Bus answer and data handoff, one cycle after the take
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
      WB_ERR_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
      RX_POP <= 1'b0;
      TX_PUSH <= 1'b0;
      TX_DATA <= 8'h00;
    end else begin
      WB_ACK_O <= req & mapped;
      WB_ERR_O <= req & ~mapped;
      WB_DAT_O <= rd_acc ? rd_data : 32'h00000000;
      RX_POP <= rd_data_buf;
      TX_PUSH <= wr_data_buf;
      if (wr_data_buf) begin
        TX_DATA <= WB_DAT_I[7:0];
      end
    end
  end

  // Aliases write their own field only
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_enable_reg_r <= `UITL_EN_RST;
      fifo_control_reg_r <= `UITL_FIFO_RST;
    end else begin
      if (wr_en_reg) begin
        irq_enable_reg_r <= WB_DAT_I[7:0] & `UITL_EN_MASK;
      end
      if (wr_fifo_ctl) begin
        fifo_control_reg_r <= WB_DAT_I[7:0] & `UITL_FIFO_MASK;
      end
      if (wr_fe) begin
        fifo_control_reg_r[0] <= WB_DAT_I[0];
      end
      if (wr_rt) begin
        fifo_control_reg_r[7:6] <= WB_DAT_I[1:0];
      end
      if (wr_tt) begin
        fifo_control_reg_r[5:4] <= WB_DAT_I[1:0];
      end
    end
  end

  // Line status: a new error wins over the clearing read
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      line_pend_r <= 1'b0;
      rx_err_r <= 4'h0;
    end else begin
      if (RX_ERR_EVENT) begin
        line_pend_r <= 1'b1;
        rx_err_r <= rx_err_r | RX_ERRORS;
      end else if (rd_line) begin
        line_pend_r <= 1'b0;
        rx_err_r <= 4'h0;
      end
    end
  end

  // Transmit empty: set on the rising source, so one read clears it
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      txe_pend_r <= 1'b0;
      txe_src_d_r <= 1'b0;
    end else begin
      txe_src_d_r <= txe_src;
      if (txe_src & ~txe_src_d_r) begin
        txe_pend_r <= 1'b1;
      end else if (~txe_src | wr_data_buf | (rd_ident & (irq_id == `UITL_ID_TXE))) begin
        txe_pend_r <= 1'b0;
      end
    end
  end

  // Character timeout: idle counter saturates, fires once
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      idle_cnt_r <= 16'h0000;
      rx_level_d_r <= 5'h00;
      cto_pend_r <= 1'b0;
    end else begin
      rx_level_d_r <= RX_LEVEL;
      if (rx_moved) begin
        idle_cnt_r <= 16'h0000;
      end else if (idle_cnt_r != TO_END) begin
        idle_cnt_r <= idle_cnt_r + 16'h0001;
      end
      if (cto_src) begin
        cto_pend_r <= 1'b1;
      end else if (rd_data_buf || RX_LEVEL == 5'h00) begin
        cto_pend_r <= 1'b0;
      end
    end
  end

  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      UART_IRQ <= 1'b0;
    end else begin
      UART_IRQ <= irq_pend;
    end
  end
endmodule // uitl_irq
`default_nettype wire

// >>> rtl/uitl_consts.vh
`ifndef UITL_CONSTS_VH
`define UITL_CONSTS_VH
// Word offsets (byte addresses on a 32-bit Wishbone bus)
`define UITL_DATA_OFS 8'h00
`define UITL_EN_OFS 8'h04
`define UITL_IDENT_OFS 8'h08
`define UITL_LINE_OFS 8'h14
`define UITL_RX_ALIAS_LO 8'h30
`define UITL_RX_ALIAS_HI 8'h6c
`define UITL_TX_ALIAS_LO 8'h30
`define UITL_TX_ALIAS_HI 8'h6c
`define UITL_FIFO_EN_ALIAS 8'h98
`define UITL_RX_TRIG_ALIAS 8'h9c
`define UITL_TX_TRIG_ALIAS 8'ha0
`define UITL_RX_STAT 8'ha4
// Field positions
`define UITL_EN_LINE 2
`define UITL_EN_DATA 0
`define UITL_EN_TXE 1
`define UITL_EN_PTHR 7
`define UITL_FIFO_ON 0
`define UITL_LINE_TXE 5
// Interrupt identification codes
`define UITL_ID_NONE 4'h1
`define UITL_ID_LINE 4'h6
`define UITL_ID_DATA 4'h4
`define UITL_ID_CTO 4'hc
`define UITL_ID_TXE 4'h2
// Writable bits and reset values
`define UITL_EN_MASK 8'h87
`define UITL_FIFO_MASK 8'hf1
`define UITL_EN_RST 8'h00
`define UITL_FIFO_RST 8'h00
// Character time in bit times, and timeout in character times
`define UITL_CHAR_BITS 10
`define UITL_TIMEOUT_CHARS 4
`endif

// >>> dv/uitl_irq_chk.sv
`timescale 1ns/100ps
`default_nettype none
module uitl_chk (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic WB_ERR_O,
  input wire logic RX_ERR_EVENT,
  input wire logic RX_POP,
  input wire logic TX_PUSH,
  input wire logic [7:0] TX_DATA,
  input wire logic UART_IRQ
);
  logic [2:0] en_copy_r;
  wire logic rd_ack = WB_ACK_O && !WB_WE_I;
  wire logic wr_ack = WB_ACK_O && WB_WE_I && WB_SEL_I[0];
  wire logic buf_hit = WB_ADR_I == 8'h00 ||
    (WB_ADR_I >= 8'h30 && WB_ADR_I <= 8'h6c && WB_ADR_I[1:0] == 2'h0);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence s_done;
    (WB_ACK_O ^ WB_ERR_O) ##1 !(WB_ACK_O || WB_ERR_O);
  endsequence
  // Enable copy lags the design by one edge, so it errs safe except in a_line_irq just after bit 2 is cleared
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) en_copy_r <= 3'h0;
    else if (wr_ack && WB_ADR_I == 8'h04) en_copy_r <= WB_DAT_I[2:0];
  end
  a_one_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O |=> s_done)
    else $error("bus answer");
  a_read_zero: assert property (!rd_ack |-> WB_DAT_O == 32'h0) else $error("read data");
  a_upper_zero: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0) else $error("upper");
  a_pop_match: assert property (RX_POP == (rd_ack && buf_hit)) else $error("pop");
  a_push_data: assert property (wr_ack && buf_hit |-> TX_PUSH && TX_DATA == WB_DAT_I[7:0])
    else $error("push");
  a_err_inert: assert property (WB_ERR_O |-> !RX_POP && !TX_PUSH) else $error("err");
  a_irq_masked: assert property ((en_copy_r == 3'h0) [*2] |-> !UART_IRQ) else $error("irq");
  a_line_irq: assert property (RX_ERR_EVENT && en_copy_r[2] |-> ##[1:2] UART_IRQ)
    else $error("line");
endmodule // uitl_chk
bind uitl_irq uitl_chk chk_u (.MCLK(MCLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
  .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O),
  .RX_ERR_EVENT(RX_ERR_EVENT), .RX_POP(RX_POP), .TX_PUSH(TX_PUSH), .TX_DATA(TX_DATA),
  .UART_IRQ(UART_IRQ));
`default_nettype wire

// >>> dv/uitl_far.sv
`timescale 1ns/100ps
`default_nettype none
module uitl_far (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic pop,
  input wire logic push,
  input wire logic in_v,
  input wire logic [7:0] in_b,
  input wire logic stall,
  output logic [7:0] rx_data = 8'h00,
  output logic rx_valid,
  output logic [4:0] rx_level = 5'h00,
  output logic [4:0] tx_level = 5'h00,
  output logic tx_empty
);
  logic [5:0] tick_r;
  assign tx_empty = tx_level == 5'h00;
  assign rx_valid = rx_level != 5'h00;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_r <= 6'h00;
      tx_level <= 5'h00;
      rx_level <= 5'h00;
      rx_data <= 8'h00;
    end else begin
      tick_r <= tick_r + 6'h01;
      // Line sends one byte every 64 clocks unless stalled or pushed in that clock
      if (push) tx_level <= tx_level + 5'h01;
      else if (!stall && tx_level != 5'h00 && tick_r == 6'h00) tx_level <= tx_level - 5'h01;
      if (in_v) begin
        rx_data <= in_b;
        rx_level <= rx_level + 5'h01;
      end else if (pop && rx_level != 5'h00) begin
        rx_level <= rx_level - 5'h01;
        rx_data <= ~rx_data;
      end
    end
  end
endmodule // uitl_far
`default_nettype wire

// >>> dv/uitl_irq_tb.sv
`timescale 1ns/100ps
`default_nettype none
module uitl_irq_tb;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic cyc = 1'b0, we = 1'b0, in_v = 1'b0, stall = 1'b0, ev = 1'b0, rerr;
  logic [7:0] adr = 8'h00, in_b = 8'h00, rxd, txd;
  logic [31:0] wdat = 32'h0, dato, rd;
  logic [4:0] rxl, txl;
  logic ack, err, rxv, pop, push, irq, hold;
  int num_errors = 0, checks = 0, ticks = 0;
  always #20 MCLK = ~MCLK;
  uitl_irq #(.BIT_CLKS(2)) dut_u (.MCLK(MCLK), .RST_N(RST_N), .WB_CYC_I(cyc), .WB_STB_I(cyc),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(dato),
    .WB_ACK_O(ack), .WB_ERR_O(err), .RX_DATA(rxd), .RX_VALID(rxv), .RX_LEVEL(rxl),
    .RX_ERRORS({2'b00, ev, 1'b0}), .RX_ERR_EVENT(ev), .TX_LEVEL(txl), .TX_HOLD_EMPTY(hold),
    .RX_POP(pop), .TX_PUSH(push), .TX_DATA(txd), .UART_IRQ(irq));
  uitl_far far_u (.mclk(MCLK), .rst_n(RST_N), .pop(pop), .push(push), .in_v(in_v), .in_b(in_b),
    .stall(stall), .rx_data(rxd), .rx_valid(rxv), .rx_level(rxl), .tx_level(txl), .tx_empty(hold));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge MCLK);
    end while (!ack && !err);
    rd = dato;
    rerr = err;
    cyc <= 1'b0;
    @(posedge MCLK);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic lsr5(input logic e);
    wb(1'b0, 8'h14, 32'h0);
    chk({31'h0, rd[5]}, {31'h0, e});
  endtask
  task automatic rx_in(input logic [7:0] b, input logic e);
    in_b <= b;
    in_v <= 1'b1;
    ev <= e;
    @(posedge MCLK);
    in_v <= 1'b0;
    ev <= 1'b0;
    @(posedge MCLK);
  endtask
  task automatic wait_irq;
    while (!irq) begin
      @(posedge MCLK);
    end
  endtask
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge MCLK) begin
    ticks++;
    if (ticks == 6000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    repeat (12) @(posedge MCLK);
    RST_N <= 1'b1;
    @(posedge MCLK);
    rchk(8'h04, 32'h0);
    rchk(8'h08, 32'h1);
    wb(1'b0, 8'h0c, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    $display("test reset end");
    wb(1'b1, 8'h04, 32'h02);
    wb(1'b1, 8'h00, 32'h5a);
    wait_irq();
    chk({31'h0, irq}, 32'h1);
    rchk(8'h08, 32'h2);
    rchk(8'h08, 32'h1);
    $display("test empty end");
    wb(1'b1, 8'h04, 32'h05);
    rx_in(8'ha5, 1'b1);
    rchk(8'h08, 32'h6);
    wb(1'b0, 8'h14, 32'h0);
    chk(rd & 32'h3f, 32'h25);
    rchk(8'h08, 32'h4);
    rchk(8'h3c, 32'ha5);
    rchk(8'h08, 32'h1);
    $display("test priority end");
    wb(1'b1, 8'h9c, 32'h3);
    wb(1'b1, 8'ha0, 32'h2);
    wb(1'b1, 8'h98, 32'h1);
    rchk(8'h9c, 32'h3);
    rchk(8'ha0, 32'h2);
    rchk(8'h98, 32'h1);
    rchk(8'h08, 32'hc1);
    stall <= 1'b1;
    wb(1'b1, 8'h04, 32'h82);
    for (int i = 0; i < 15; i++) wb(1'b1, 8'h30 + 8'(4 * i), 32'(i));
    lsr5(1'b0);
    wb(1'b1, 8'h6c, 32'hff);
    lsr5(1'b1);
    wb(1'b1, 8'h98, 32'h0);
    lsr5(1'b0);
    wb(1'b1, 8'h98, 32'h1);
    stall <= 1'b0;
    wait_irq();
    chk({27'h0, txl}, 32'h4);
    rchk(8'h08, 32'hc2);
    $display("test threshold end");
    wb(1'b1, 8'h04, 32'h01);
    rx_in(8'h3c, 1'b0);
    repeat (60) @(posedge MCLK);
    rchk(8'h08, 32'hc1);
    repeat (30) @(posedge MCLK);
    rchk(8'h08, 32'hcc);
    rchk(8'h00, 32'h3c);
    rchk(8'h08, 32'hc1);
    $display("test timeout end");
    close_out();
  end
endmodule // uitl_irq_tb
`default_nettype wire
